/* hdl/power_on_self_test.sv */
// Power-on self-test sequencer: memory test, peripheral register test, result
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - After reset run memory then register test.
// - Write AA and 55, read, compare.
// - Then write address-byte XOR, read, compare.
// - Video bank 7 C000-CFFF tested first.
// - Then bank 8, bank 0, bank 1.
// - Write and read back peripheral registers.
// - Skip disk controller and timer ports.
// - All pass: beep once, then hand over.
// - Any mismatch raises the failure indication.
// - Sequence spans about 7.5 seconds overall.
// - Accesses paced at 4 MHz processor clock.
// - Refresh has priority; stall and retry.
module power_on_self_test #(
    parameter int unsigned SELFTEST_CYCLES = post_pkg::SELFTEST_CYCLES,
    parameter int unsigned BEEP_CYCLES = post_pkg::BEEP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    output logic bus_req,
    output logic bus_io,
    output logic bus_we,
    output logic [3:0] bus_bank,
    output logic [15:0] bus_addr,
    output logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_ack,
    input wire logic refresh_hold,
    output logic selftest_busy,
    output logic beep,
    output logic handover,
    output logic selftest_fail,
    output logic [3:0] fail_bank,
    output logic [15:0] fail_addr
);

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {S_START, S_SAVE, S_WR_A, S_RD_A, S_WR_B, S_RD_B, S_WR_X, S_RD_X,
        S_RESTORE, S_IO_WR, S_IO_RD, S_WAIT, S_BEEP, S_DONE, S_FAIL} seq_state_t;

    seq_state_t state_reg, state_next;       // Current step
    logic issued_reg, issued_next;           // Access for this step under way
    logic [1:0] region_reg, region_next;     // Memory region index
    logic [15:0] addr_reg, addr_next;        // Location under test
    logic [7:0] saved_reg, saved_next;       // Original byte of the location
    logic [2:0] io_idx_reg, io_idx_next;     // Peripheral entry index
    logic err_reg, err_next;                 // A mismatch was seen
    logic [31:0] time_reg, time_next;        // Cycles since reset release
    logic [31:0] beep_reg, beep_next;        // Alarm length counter
    logic [3:0] fbank_reg, fbank_next;       // Bank of first failure
    logic [15:0] faddr_reg, faddr_next;      // Address or port of first failure

    // Access engine handshake
    logic acc_start, acc_io, acc_we, acc_done;
    logic [7:0] acc_wdata, acc_rdata;
    logic [3:0] acc_bank;
    logic [15:0] acc_addr;

    // Region and peripheral lookup
    logic [3:0] cur_bank;
    logic [15:0] cur_start, cur_end;
    logic [7:0] io_port, io_val;
    logic [7:0] xor_val;

    // ------------------------------------------------------------
    // Region table, video first then the rest in turn
    // ------------------------------------------------------------
    always_comb begin
        case (region_reg)
            2'd0: {cur_bank, cur_start, cur_end} =
                {post_pkg::REG0_BANK, post_pkg::REG0_START, post_pkg::REG0_END};
            2'd1: {cur_bank, cur_start, cur_end} =
                {post_pkg::REG1_BANK, post_pkg::REG1_START, post_pkg::REG1_END};
            2'd2: {cur_bank, cur_start, cur_end} =
                {post_pkg::REG2_BANK, post_pkg::REG2_START, post_pkg::REG2_END};
            default: {cur_bank, cur_start, cur_end} =
                {post_pkg::REG3_BANK, post_pkg::REG3_START, post_pkg::REG3_END};
        endcase
    end

    // ------------------------------------------------------------
    // Peripheral table; disk controller and timer ports never appear
    // ------------------------------------------------------------
    always_comb begin
        io_val = io_idx_reg[0] ? post_pkg::IO_VAL_ODD : post_pkg::IO_VAL_EVEN;
        case (io_idx_reg)
            3'd0: io_port = post_pkg::IO_PORT0;
            3'd1: io_port = post_pkg::IO_PORT1;
            3'd2: io_port = post_pkg::IO_PORT2;
            3'd3: io_port = post_pkg::IO_PORT3;
            3'd4: io_port = post_pkg::IO_PORT4;
            3'd5: io_port = post_pkg::IO_PORT5;
            3'd6: io_port = post_pkg::IO_PORT6;
            default: io_port = post_pkg::IO_PORT7;
        endcase
    end

    // Hash value: high address byte XOR low address byte
    assign xor_val = addr_reg[15:8] ^ addr_reg[7:0];

    // ------------------------------------------------------------
    // Access request for the current step
    // ------------------------------------------------------------
    always_comb begin
        acc_start = 1'b0;
        acc_io = 1'b0;
        acc_we = 1'b0;
        acc_bank = cur_bank;
        acc_addr = addr_reg;
        acc_wdata = 8'h00;
        case (state_reg)
            S_SAVE, S_RD_A, S_RD_B, S_RD_X: acc_start = !issued_reg;
            S_WR_A, S_WR_B, S_WR_X, S_RESTORE: begin
                acc_start = !issued_reg;
                acc_we = 1'b1;
                // Fill pattern, address checksum, or the original byte put back
                acc_wdata = (state_reg == S_WR_A) ? post_pkg::PAT_A :
                            (state_reg == S_WR_B) ? post_pkg::PAT_B :
                            (state_reg == S_WR_X) ? xor_val : saved_reg;
            end
            S_IO_WR, S_IO_RD: begin
                acc_start = !issued_reg;
                acc_io = 1'b1;
                acc_we = (state_reg == S_IO_WR);
                acc_bank = 4'h0;
                acc_addr = {8'h00, io_port};
                acc_wdata = io_val;
            end
            default: acc_start = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic mismatch;
        logic [7:0] expect_val;
        mismatch = 1'b0;
        expect_val = 8'h00;
        state_next = state_reg;
        issued_next = issued_reg || acc_start; // Held once the step's access is launched
        region_next = region_reg;
        addr_next = addr_reg;
        saved_next = saved_reg;
        io_idx_next = io_idx_reg;
        err_next = err_reg;
        time_next = (time_reg == 32'hffffffff) ? time_reg : time_reg + 32'h1;
        beep_next = beep_reg;
        fbank_next = fbank_reg;
        faddr_next = faddr_reg;

        // Expected read value per read-back step
        case (state_reg)
            S_RD_A: expect_val = post_pkg::PAT_A;
            S_RD_B: expect_val = post_pkg::PAT_B;
            S_RD_X: expect_val = xor_val;
            S_IO_RD: expect_val = io_val;
            default: expect_val = acc_rdata; // Save reads and writes carry no verdict
        endcase
        mismatch = acc_done && (acc_rdata != expect_val);

        case (state_reg)
            S_START: begin
                // Entered uncommanded after reset and at each new region
                addr_next = cur_start;
                state_next = S_SAVE;
            end
            S_SAVE: if (acc_done) begin
                saved_next = acc_rdata;
                issued_next = 1'b0;
                state_next = S_WR_A;
            end
            S_WR_A, S_WR_B, S_WR_X, S_IO_WR: if (acc_done) begin
                issued_next = 1'b0;
                state_next = (state_reg == S_WR_A) ? S_RD_A :
                             (state_reg == S_WR_B) ? S_RD_B :
                             (state_reg == S_WR_X) ? S_RD_X : S_IO_RD;
            end
            S_RD_A, S_RD_B, S_RD_X: if (acc_done) begin
                issued_next = 1'b0;
                // A failed location is still restored before stopping
                state_next = mismatch ? S_RESTORE :
                             (state_reg == S_RD_A) ? S_WR_B :
                             (state_reg == S_RD_B) ? S_WR_X : S_RESTORE;
            end
            S_RESTORE: if (acc_done) begin
                issued_next = 1'b0;
                if (err_reg) begin
                    state_next = S_FAIL;
                end else if (addr_reg != cur_end) begin
                    addr_next = addr_reg + 16'h0001;
                    state_next = S_SAVE;
                end else if (region_reg != 2'(post_pkg::NUM_REGIONS - 1)) begin
                    region_next = region_reg + 2'd1;
                    state_next = S_START;
                end else begin
                    // Memory finished: peripheral registers next
                    io_idx_next = 3'd0;
                    state_next = S_IO_WR;
                end
            end
            S_IO_RD: if (acc_done) begin
                issued_next = 1'b0;
                if (mismatch) begin
                    state_next = S_FAIL;
                end else if (io_idx_reg != 3'(post_pkg::NUM_IO - 1)) begin
                    io_idx_next = io_idx_reg + 3'd1;
                    state_next = S_IO_WR;
                end else begin
                    state_next = S_WAIT;
                end
            end
            S_WAIT: begin
                // Hold the result until the nominal test time has elapsed
                if (time_reg >= SELFTEST_CYCLES - 1) begin
                    beep_next = 32'h0;
                    state_next = S_BEEP;
                end
            end
            S_BEEP: begin
                // Single alarm, then hand over
                beep_next = beep_reg + 32'h1;
                if (beep_reg >= BEEP_CYCLES - 1) begin
                    state_next = S_DONE;
                end
            end
            S_DONE, S_FAIL: state_next = state_reg;
            default: state_next = S_FAIL;
        endcase

        // Record first failing location
        if (mismatch && !err_reg) begin
            err_next = 1'b1;
            fbank_next = acc_io ? 4'h0 : cur_bank;
            faddr_next = acc_addr;
        end
    end

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= S_START;
            issued_reg <= 1'b0;
            region_reg <= 2'd0;
            addr_reg <= 16'h0000;
            saved_reg <= 8'h00;
            io_idx_reg <= 3'd0;
            err_reg <= 1'b0;
            time_reg <= 32'h0;
            beep_reg <= 32'h0;
            fbank_reg <= 4'h0;
            faddr_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            issued_reg <= issued_next;
            region_reg <= region_next;
            addr_reg <= addr_next;
            saved_reg <= saved_next;
            io_idx_reg <= io_idx_next;
            err_reg <= err_next;
            time_reg <= time_next;
            beep_reg <= beep_next;
            fbank_reg <= fbank_next;
            faddr_reg <= faddr_next;
        end
    end

    // ------------------------------------------------------------
    // Bus access engine
    // ------------------------------------------------------------
    bus_access #(.DIV(post_pkg::CPU_DIV)) u_access (
        .sys_clk, .rst_n, .start(acc_start), .io_in(acc_io), .we_in(acc_we),
        .bank_in(acc_bank), .addr_in(acc_addr), .wdata_in(acc_wdata), .done(acc_done),
        .rdata(acc_rdata), .bus_req, .bus_io, .bus_we, .bus_bank, .bus_addr, .bus_wdata,
        .bus_rdata, .bus_ack, .refresh_hold
    );

    // Status outputs, all decoded from registers
    assign selftest_busy = (state_reg != S_DONE) && (state_reg != S_FAIL);
    assign beep = (state_reg == S_BEEP);
    assign handover = (state_reg == S_DONE);
    assign selftest_fail = (state_reg == S_FAIL);
    assign fail_bank = fbank_reg;
    assign fail_addr = faddr_reg;

endmodule

`default_nettype wire

/* hdl/post_pkg.sv */
// Shared constants for the power-on self-test sequencer
package post_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ = 40_000_000;  // System clock rate
    localparam int unsigned OSC_HZ = 24_000_000;      // Reference oscillator
    localparam int unsigned CPU_CLK_HZ = 4_000_000;   // Processor clock pacing test accesses
    localparam int unsigned CPU_DIV = SYS_CLK_HZ / CPU_CLK_HZ; // sys_clk edges per CPU tick
    localparam int unsigned SELFTEST_MS = 7500;       // Whole sequence, in milliseconds
    localparam int unsigned SELFTEST_CYCLES = SELFTEST_MS * (SYS_CLK_HZ / 1000);
    localparam int unsigned BEEP_MS = 100;            // Operator alarm length, milliseconds
    localparam int unsigned BEEP_CYCLES = BEEP_MS * (SYS_CLK_HZ / 1000);

    // ------------------------------------------------------------
    // Memory test patterns
    // ------------------------------------------------------------
    localparam logic [7:0] PAT_A = 8'haa;             // First fill pattern
    localparam logic [7:0] PAT_B = 8'h55;             // Second fill pattern

    // ------------------------------------------------------------
    // Regions under test, in test order
    // ------------------------------------------------------------
    localparam int unsigned NUM_REGIONS = 4;
    localparam logic [3:0] REG0_BANK = 4'h7;          // Video memory
    localparam logic [15:0] REG0_START = 16'hc000;
    localparam logic [15:0] REG0_END = 16'hcfff;
    localparam logic [3:0] REG1_BANK = 4'h8;          // Support RAM
    localparam logic [15:0] REG1_START = 16'h2000;
    localparam logic [15:0] REG1_END = 16'h27ff;
    localparam logic [3:0] REG2_BANK = 4'h0;          // Main bank 0
    localparam logic [15:0] REG2_START = 16'h3000;
    localparam logic [15:0] REG2_END = 16'hffff;
    localparam logic [3:0] REG3_BANK = 4'h1;          // Main bank 1
    localparam logic [15:0] REG3_START = 16'h4000;
    localparam logic [15:0] REG3_END = 16'hefff;

    // ------------------------------------------------------------
    // Peripheral register test: disk controller 08-0b and timer 04-07 absent
    // ------------------------------------------------------------
    localparam int unsigned NUM_IO = 8;
    localparam logic [7:0] IO_VAL_EVEN = 8'ha5;       // Known value, even entries
    localparam logic [7:0] IO_VAL_ODD = 8'h5a;        // Known value, odd entries
    localparam logic [7:0] IO_PORT0 = 8'h00;          // System select adapter
    localparam logic [7:0] IO_PORT1 = 8'h01;
    localparam logic [7:0] IO_PORT2 = 8'h02;
    localparam logic [7:0] IO_PORT3 = 8'h03;
    localparam logic [7:0] IO_PORT4 = 8'h10;          // Parallel adapter
    localparam logic [7:0] IO_PORT5 = 8'h11;
    localparam logic [7:0] IO_PORT6 = 8'h12;
    localparam logic [7:0] IO_PORT7 = 8'h13;

endpackage

/* hdl/bus_access.sv */
// Single bus access engine with processor-clock pacing and refresh retry
`timescale 1ns/10ps
`default_nettype none

module bus_access #(
    parameter int unsigned DIV = post_pkg::CPU_DIV
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic io_in,
    input wire logic we_in,
    input wire logic [3:0] bank_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic done,
    output logic [7:0] rdata,
    output logic bus_req,
    output logic bus_io,
    output logic bus_we,
    output logic [3:0] bus_bank,
    output logic [15:0] bus_addr,
    output logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_ack,
    input wire logic refresh_hold
);

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {A_IDLE, A_WAIT, A_BUS, A_DONE} acc_state_t;

    acc_state_t state_reg, state_next;       // Access phase
    logic [7:0] tick_reg, tick_next;         // Processor clock divider
    logic req_reg, req_next;                 // Request pin
    logic io_reg, io_next;                   // I/O space select
    logic we_reg, we_next;                   // Write strobe
    logic [3:0] bank_reg, bank_next;         // Bank select
    logic [15:0] addr_reg, addr_next;        // Address
    logic [7:0] wdata_reg, wdata_next;       // Write data
    logic [7:0] rdata_reg, rdata_next;       // Captured read data
    logic tick;                              // One CPU clock period passed

    assign tick = (tick_reg == 8'(DIV - 1));

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        tick_next = tick ? 8'h00 : tick_reg + 8'h01;
        req_next = req_reg;
        io_next = io_reg;
        we_next = we_reg;
        bank_next = bank_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        case (state_reg)
            A_IDLE: begin
                // Latch the request so the caller may change its inputs
                if (start) begin
                    io_next = io_in;
                    we_next = we_in;
                    bank_next = bank_in;
                    addr_next = addr_in;
                    wdata_next = wdata_in;
                    state_next = A_WAIT;
                end
            end
            A_WAIT: begin
                // Issue on a CPU tick only, and never while refresh owns memory
                if (tick && !(refresh_hold && !io_reg)) begin
                    req_next = 1'b1;
                    state_next = A_BUS;
                end
            end
            A_BUS: begin
                if (bus_ack) begin
                    req_next = 1'b0;
                    rdata_next = bus_rdata;
                    state_next = A_DONE;
                end else if (refresh_hold && !io_reg) begin
                    // Refresh won the bus: back off and retry, no failure
                    req_next = 1'b0;
                    state_next = A_WAIT;
                end
            end
            A_DONE: begin
                state_next = A_IDLE;
            end
            default: begin
                req_next = 1'b0;
                state_next = A_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= A_IDLE;
            tick_reg <= 8'h00;
            req_reg <= 1'b0;
            io_reg <= 1'b0;
            we_reg <= 1'b0;
            bank_reg <= 4'h0;
            addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
            rdata_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            tick_reg <= tick_next;
            req_reg <= req_next;
            io_reg <= io_next;
            we_reg <= we_next;
            bank_reg <= bank_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
        end
    end

    assign done = (state_reg == A_DONE);
    assign rdata = rdata_reg;
    assign bus_req = req_reg;
    assign bus_io = io_reg;
    assign bus_we = we_reg;
    assign bus_bank = bank_reg;
    assign bus_addr = addr_reg;
    assign bus_wdata = wdata_reg;

endmodule

`default_nettype wire

/* tb/post_sva.sv */
// Port assertions for the self-test sequencer
`timescale 1ns/10ps
`default_nettype none
module post_sva (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic bus_req,
    input wire logic bus_io,
    input wire logic bus_we,
    input wire logic [3:0] bus_bank,
    input wire logic [15:0] bus_addr,
    input wire logic bus_ack,
    input wire logic refresh_hold,
    input wire logic selftest_busy,
    input wire logic beep,
    input wire logic handover,
    input wire logic selftest_fail
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] gap_reg; // Cycles since last request start
    logic [7:0] gap_next;
    logic req_reg; // Request one cycle back
    // Restart on a rising request; saturate so long idles never wrap
    always_comb begin
        gap_next = (bus_req && !req_reg) ? 8'h01 : gap_reg + {7'h00, gap_reg != 8'hff};
    end
    always_ff @(posedge sys_clk) begin
        gap_reg <= rst_n ? gap_next : 8'hff;
        req_reg <= rst_n && bus_req;
    end
    property p_stand; bus_req && !bus_ack && (bus_io || !refresh_hold)
        |=> bus_req && $stable({bus_we, bus_bank, bus_addr}); endproperty
    a_stand: assert property (p_stand) else $error("request moved");
    property p_drop; bus_req && bus_ack |=> !bus_req; endproperty
    a_drop: assert property (p_drop) else $error("request after ack");
    property p_yield; bus_req && !bus_ack && !bus_io && refresh_hold |=> !bus_req; endproperty
    a_yield: assert property (p_yield) else $error("refresh not yielded");
    property p_pace; $rose(bus_req) |-> gap_reg >= 8'd10; endproperty
    a_pace: assert property (p_pace) else $error("starts too close");
    property p_skip; bus_req && bus_io |-> bus_bank == 4'h0 && bus_addr[15:8] == 8'h00
        && !(bus_addr[7:0] inside {[8'h04:8'h0b]}); endproperty
    a_skip: assert property (p_skip) else $error("excluded port");
    property p_fail; selftest_fail
        |=> selftest_fail && !selftest_busy && !beep && !handover && !bus_req; endproperty
    a_fail: assert property (p_fail) else $error("failure not final");
    property p_hand; handover |=> handover && !beep && !selftest_fail; endproperty
    a_hand: assert property (p_hand) else $error("handover not final");
    property p_start; $rose(rst_n)
        |-> selftest_busy && !bus_req && !beep && !handover && !selftest_fail; endproperty
    a_start: assert property (p_start) else $error("bad start state");
    c_stall: cover property (bus_req && !bus_io && refresh_hold && !bus_ack);
    c_fail: cover property ($rose(selftest_fail));
    c_write: cover property (bus_req && bus_ack && bus_we);
endmodule
bind power_on_self_test post_sva chk (.sys_clk, .rst_n, .bus_req, .bus_io, .bus_we,
    .bus_bank, .bus_addr, .bus_ack, .refresh_hold, .selftest_busy, .beep, .handover,
    .selftest_fail);
`default_nettype wire

/* tb/mem_model.sv */
// Far-side model of memory and peripheral registers; all banks share one store
`timescale 1ns/10ps
`default_nettype none
module mem_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic bus_req,
    input wire logic bus_io,
    input wire logic bus_we,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic refresh_hold,
    input wire logic slow,
    input wire logic [15:0] bad_addr,
    output logic [7:0] bus_rdata,
    output logic bus_ack
);
    logic [7:0] mem [logic [16:0]]; // Sparse store, port space on top bit
    logic [1:0] wait_reg = 2'd0; // Stall left before answering
    logic [7:0] v; // Stored or power-up value
    logic bad; // Spoil the checksum readback here
    initial begin
        bus_rdata = 8'h00;
        bus_ack = 1'b0;
    end
    // One answer per request; idle data toggles so nothing stale looks valid
    always @(posedge sys_clk) begin
        v = mem.exists({bus_io, bus_addr}) ? mem[{bus_io, bus_addr}] : bus_addr[7:0] ^ 8'h3c;
        bad = !bus_io && bus_addr == bad_addr && v == (bus_addr[15:8] ^ bus_addr[7:0]);
        if (!rst_n || !bus_req || bus_ack) begin
            bus_ack <= 1'b0;
            bus_rdata <= ~bus_rdata;
            wait_reg <= slow ? 2'd3 : 2'd0;
        end else if (wait_reg != 2'd0) begin
            wait_reg <= wait_reg - 2'd1;
        end else if (bus_io || !refresh_hold) begin
            bus_ack <= 1'b1;
            if (bus_we) begin
                mem[{bus_io, bus_addr}] = bus_wdata;
            end
            bus_rdata <= v ^ {7'h00, bad};
        end
    end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the power-on self-test sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0; // 40 MHz
    logic rst_n = 1'b0;
    logic refresh_hold = 1'b0;
    logic slow = 1'b0;
    logic [15:0] bad_addr = 16'h0000; // Location whose checksum read is spoiled
    logic bus_req, bus_io, bus_we, bus_ack, selftest_busy, beep, handover, selftest_fail;
    logic [3:0] bus_bank, fail_bank;
    logic [15:0] bus_addr, fail_addr;
    logic [7:0] bus_wdata, bus_rdata;
    logic [24:0] e; // Expected write flag, address, data
    logic hit;
    logic [7:0] orig = 8'h00; // Byte seen by the save read, owed back by the restore
    int n_mismatch = 0;
    int n_checks = 0;
    int n_acc = 0; // Accesses since reset
    always #12.5 sys_clk = ~sys_clk;
    power_on_self_test #(.SELFTEST_CYCLES(1000), .BEEP_CYCLES(8)) dut (.sys_clk, .rst_n,
        .bus_req, .bus_io, .bus_we, .bus_bank, .bus_addr, .bus_wdata, .bus_rdata, .bus_ack,
        .refresh_hold, .selftest_busy, .beep, .handover, .selftest_fail, .fail_bank, .fail_addr);
    mem_model model (.sys_clk, .rst_n, .bus_req, .bus_io, .bus_we, .bus_addr, .bus_wdata,
        .refresh_hold, .slow, .bad_addr, .bus_rdata, .bus_ack);
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    // Per location: read, AA, read, 55, read, checksum, read, restore
    function automatic logic [24:0] exp_acc(input int i, input logic [7:0] orig);
        logic [15:0] a;
        a = 16'hc000 + 16'(i / 8);
        case (i % 8)
            1: return {1'b1, a, 8'haa};
            3: return {1'b1, a, 8'h55};
            5: return {1'b1, a, a[15:8] ^ a[7:0]};
            7: return {1'b1, a, orig};
            default: return {1'b0, a, 8'h00};
        endcase
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Refresh steals about a quarter of cycles; answers vary in speed
    always @(posedge sys_clk) begin
        refresh_hold <= ($urandom % 4) == 0;
        slow <= 1'($urandom % 2);
    end
    // Every completed access is compared with the expected order
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            n_acc = 0;
        end else if (bus_req === 1'b1 && bus_ack === 1'b1) begin
            e = exp_acc(n_acc, orig);
            hit = bus_we === e[24] && bus_addr === e[23:8] && bus_bank === 4'h7;
            check(hit && bus_io === 1'b0 && (!e[24] || bus_wdata === e[7:0]), "order");
            if (n_acc % 8 == 0) begin
                orig = bus_rdata;
            end
            n_acc++;
        end
    end
    // --------------------------------
    // Tests
    // --------------------------------
    initial begin
        int i;
        int k;
        void'($urandom(32'hb368dce9));
        k = $urandom % 8;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        bad_addr <= 16'hc000 + 16'(k);
        for (i = 0; i < 4000 && selftest_fail !== 1'b1; i++) @(posedge sys_clk);
        @(negedge sys_clk);
        check(selftest_fail === 1'b1 && selftest_busy === 1'b0, "no fail");
        check(fail_bank === 4'h7 && fail_addr === 16'hc000 + 16'(k), "fail where");
        check(n_acc === 8 * k + 8, "restore");
        check(beep === 1'b0 && handover === 1'b0, "beep on fail");
        $display("test fail_path done");
        @(posedge sys_clk);
        rst_n <= 1'b0;
        bad_addr <= 16'h0000;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (300) @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (1500) @(posedge sys_clk);
        @(negedge sys_clk);
        check(selftest_fail === 1'b0 && selftest_busy === 1'b1, "halted");
        check(n_acc > 30, "stalled");
        $display("test restart done");
        final_report();
    end
    // Whole run needs well under 10000 cycles
    initial begin
        #(10000 * 25);
        n_mismatch++;
        $display("ERROR %0t watchdog", $time);
        final_report();
    end
endmodule
`default_nettype wire
